//--- rtl/bid_pkg.sv
// Constants, types and register map of the branch and increment/decrement executor.
//////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RL1: Decrement-and-skip subtracts one, writes the chosen destination, keeps every flag.
// RL2: Nonzero decrement result runs next instruction; zero result turns it into a NOP.
// RL3: Increment-and-skip adds one, keeps flags, zero result turns next instruction into NOP.
// RL4: Branch loads 11-bit literal into pc 10..0 and latch bits 6..3 into pc 14..11.
// RL5: Branch always takes two instruction cycles and leaves every flag alone.
// RL6: OR-literal ORs the 8-bit literal into the accumulator and updates the zero flag.
// RL7: Plain increment adds one, writes the chosen destination, updates zero, never skips.
// RL8: Destination bit 0 writes the accumulator, 1 writes back to the file register.
// RL9: Zero flag follows an 8-bit zero result, only for instructions that affect it.
// RL10: File operand is a 7-bit address of 128 locations; increment and decrement wrap.
//////////////////////////////////////////////////////////////////////////////////
package bid_pkg;

	// Data path widths.
	localparam int DATA_W  = 8;
	localparam int INSTR_W = 14;
	localparam int PC_W    = 15;
	localparam int FADDR_W = 7;
	localparam int LATCH_W = 7;
	localparam int TGT_W   = 11;
	localparam int RADDR_W = 3;

	// Instruction and latch field positions.
	localparam int DEST_BIT   = 7;
	localparam int LATCH_LO   = 3;
	localparam int LATCH_HI   = 6;

	// Opcode match and mask patterns.
	localparam logic [INSTR_W-1:0] MASK_FILE  = 14'h3f00;
	localparam logic [INSTR_W-1:0] MASK_BR    = 14'h3800;
	localparam logic [INSTR_W-1:0] MATCH_DSZ  = 14'h0b00;
	localparam logic [INSTR_W-1:0] MATCH_ISZ  = 14'h0f00;
	localparam logic [INSTR_W-1:0] MATCH_INC  = 14'h0a00;
	localparam logic [INSTR_W-1:0] MATCH_BR   = 14'h2800;
	localparam logic [INSTR_W-1:0] MATCH_IOR  = 14'h3800;

	// Register offsets.
	localparam logic [RADDR_W-1:0] OFS_ACC    = 3'h0;
	localparam logic [RADDR_W-1:0] OFS_LATCH  = 3'h1;
	localparam logic [RADDR_W-1:0] OFS_STATUS = 3'h2;
	localparam logic [RADDR_W-1:0] OFS_PCL    = 3'h3;
	localparam logic [RADDR_W-1:0] OFS_PCH    = 3'h4;
	localparam logic [RADDR_W-1:0] OFS_CTRL   = 3'h5;

	// Status and control bit positions.
	localparam int ST_ZERO  = 0;
	localparam int ST_SKIP  = 1;
	localparam int ST_FLUSH = 2;
	localparam int CT_RUN   = 0;

	// Values after reset.
	localparam logic [DATA_W-1:0]  RST_ACC   = 8'h00;
	localparam logic [LATCH_W-1:0] RST_LATCH = 7'h00;
	localparam logic [PC_W-1:0]    RST_PC    = 15'h0000;
	localparam logic               RST_ZERO  = 1'b0;
	localparam logic               RST_RUN   = 1'b1;

	// Decoded operations.
	typedef enum logic [2:0] {
		OP_NONE,
		OP_DSZ,
		OP_ISZ,
		OP_INC,
		OP_BR,
		OP_IOR
	} bid_op_type;

endpackage : bid_pkg

//--- rtl/bid_decode.sv
// Instruction word decoder of the executor.
`timescale 1ns/1ps
`default_nettype none
module bid_decode (
	// Instruction word.
	input  wire logic [bid_pkg::INSTR_W-1:0] instr,
	// Decoded fields.
	output bid_pkg::bid_op_type              op,
	output logic                             dest,
	output logic [bid_pkg::FADDR_W-1:0]      faddr,
	output logic [bid_pkg::DATA_W-1:0]       lit,
	output logic [bid_pkg::TGT_W-1:0]        target
);

	//////////////////////////////////////////////////////////////////////////
	always_comb begin
		if ((instr & bid_pkg::MASK_FILE) == bid_pkg::MATCH_DSZ) begin
			op = bid_pkg::OP_DSZ;
		end else if ((instr & bid_pkg::MASK_FILE) == bid_pkg::MATCH_ISZ) begin
			op = bid_pkg::OP_ISZ;
		end else if ((instr & bid_pkg::MASK_FILE) == bid_pkg::MATCH_INC) begin
			op = bid_pkg::OP_INC;
		end else if ((instr & bid_pkg::MASK_FILE) == bid_pkg::MATCH_IOR) begin
			op = bid_pkg::OP_IOR;
		end else if ((instr & bid_pkg::MASK_BR) == bid_pkg::MATCH_BR) begin
			op = bid_pkg::OP_BR;
		end else begin
			op = bid_pkg::OP_NONE;
		end
	end

	assign dest   = instr[bid_pkg::DEST_BIT];                          // RL8
	assign faddr  = instr[bid_pkg::FADDR_W-1:0];                       // RL10
	assign lit    = instr[bid_pkg::DATA_W-1:0];
	assign target = instr[bid_pkg::TGT_W-1:0];

endmodule : bid_decode
`default_nettype wire

//--- rtl/bid_alu.sv
// Arithmetic unit: increment, decrement and OR with zero detection.
`timescale 1ns/1ps
`default_nettype none
module bid_alu #(
	parameter int WIDTH = 8
) (
	// Operation and operands.
	input  wire bid_pkg::bid_op_type  op,
	input  wire logic [WIDTH-1:0]     acc,
	input  wire logic [WIDTH-1:0]     fdata,
	input  wire logic [WIDTH-1:0]     lit,
	// Results.
	output logic [WIDTH-1:0]          result,
	output logic                      zero,
	output logic                      skip
);

	if (WIDTH != bid_pkg::DATA_W) begin : g_width_check
		$error("bid_alu: WIDTH must equal the core data width");
	end

	//////////////////////////////////////////////////////////////////////////
	always_comb begin
		case (op)
			bid_pkg::OP_DSZ: result = WIDTH'(fdata - WIDTH'(1));   // RL1 RL10
			bid_pkg::OP_ISZ: result = WIDTH'(fdata + WIDTH'(1));   // RL3 RL10
			bid_pkg::OP_INC: result = WIDTH'(fdata + WIDTH'(1));   // RL7 RL10
			bid_pkg::OP_IOR: result = acc | lit;                   // RL6
			default:         result = '0;
		endcase
	end

	assign zero = (result == '0);                                  // RL9
	assign skip = zero && (op == bid_pkg::OP_DSZ || op == bid_pkg::OP_ISZ); // RL2 RL3

endmodule : bid_alu
`default_nettype wire

//--- rtl/bid_core.sv
// Executor of skip, increment, branch and OR-literal instructions with register port.
//
// The implementer's own choices: the address map and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module bid_core (
	// Clock and reset.
	input  wire logic                        clk,
	input  wire logic                        nrst,
	// Program memory.
	input  wire logic                        instr_valid,
	input  wire logic [bid_pkg::INSTR_W-1:0] instr,
	output logic [bid_pkg::PC_W-1:0]         pc,
	output logic                             instr_nop,
	// Data file registers.
	output logic [bid_pkg::FADDR_W-1:0]      file_addr,
	input  wire logic [bid_pkg::DATA_W-1:0]  file_rdata,
	output logic                             file_we,
	output logic [bid_pkg::DATA_W-1:0]       file_wdata,
	// Register port.
	input  wire logic [bid_pkg::RADDR_W-1:0] reg_addr,
	input  wire logic [bid_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic [bid_pkg::DATA_W-1:0]       reg_rdata
);

	//////////////////////////////////////////////////////////////////////////
	// Reset release synchroniser.
	logic rst_meta_reg;
	logic rst_n;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_meta_reg <= 1'b0;
			rst_n        <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n        <= rst_meta_reg;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// Decode and arithmetic.
	bid_pkg::bid_op_type              op;
	logic                             dest;
	logic [bid_pkg::FADDR_W-1:0]      faddr;
	logic [bid_pkg::DATA_W-1:0]       lit;
	logic [bid_pkg::TGT_W-1:0]        target;
	logic [bid_pkg::DATA_W-1:0]       result;
	logic                             alu_zero;
	logic                             alu_skip;

	bid_decode u_decode (
		.instr  (instr),
		.op     (op),
		.dest   (dest),
		.faddr  (faddr),
		.lit    (lit),
		.target (target)
	);

	logic [bid_pkg::DATA_W-1:0]       acc_reg;
	logic [bid_pkg::DATA_W-1:0]       acc_next;

	bid_alu #(
		.WIDTH (bid_pkg::DATA_W)
	) u_alu (
		.op     (op),
		.acc    (acc_reg),
		.fdata  (file_rdata),
		.lit    (lit),
		.result (result),
		.zero   (alu_zero),
		.skip   (alu_skip)
	);

	//////////////////////////////////////////////////////////////////////////
	// Execution state.
	logic [bid_pkg::LATCH_W-1:0]      latch_reg;
	logic [bid_pkg::LATCH_W-1:0]      latch_next;
	logic [bid_pkg::PC_W-1:0]         pc_reg;
	logic [bid_pkg::PC_W-1:0]         pc_next;
	logic                             zero_reg;
	logic                             zero_next;
	logic                             skip_reg;
	logic                             skip_next;
	logic                             flush_reg;
	logic                             flush_next;
	logic                             run_reg;
	logic                             run_next;
	logic                             step;
	logic                             exec;
	logic                             file_op;

	assign step    = instr_valid && run_reg;
	assign exec    = step && !skip_reg && !flush_reg;
	assign file_op = (op == bid_pkg::OP_DSZ) || (op == bid_pkg::OP_ISZ) || (op == bid_pkg::OP_INC);

	always_comb begin
		acc_next   = acc_reg;
		latch_next = latch_reg;
		pc_next    = pc_reg;
		zero_next  = zero_reg;
		skip_next  = skip_reg;
		flush_next = flush_reg;
		run_next   = run_reg;
		// Software writes come first so that a same-cycle instruction result wins.
		if (reg_wr) begin
			case (reg_addr)
				bid_pkg::OFS_ACC:    acc_next   = reg_wdata;
				bid_pkg::OFS_LATCH:  latch_next = reg_wdata[bid_pkg::LATCH_W-1:0];
				bid_pkg::OFS_STATUS: zero_next  = reg_wdata[bid_pkg::ST_ZERO];
				bid_pkg::OFS_CTRL:   run_next   = reg_wdata[bid_pkg::CT_RUN];
				default:             ;
			endcase
		end
		if (step) begin
			pc_next    = bid_pkg::PC_W'(pc_reg + bid_pkg::PC_W'(1));
			skip_next  = 1'b0;                                   // RL2 RL3
			flush_next = 1'b0;                                   // RL5
		end
		if (exec) begin
			case (op)
				bid_pkg::OP_DSZ,
				bid_pkg::OP_ISZ: begin
					if (!dest) begin
						acc_next = result;                       // RL1 RL3 RL8
					end
					skip_next = alu_skip;                        // RL2 RL3
				end
				bid_pkg::OP_INC: begin
					if (!dest) begin
						acc_next = result;                       // RL7 RL8
					end
					zero_next = alu_zero;                        // RL7 RL9
				end
				bid_pkg::OP_IOR: begin
					acc_next  = result;                          // RL6
					zero_next = alu_zero;                        // RL6 RL9
				end
				bid_pkg::OP_BR: begin
					pc_next    = {latch_reg[bid_pkg::LATCH_HI:bid_pkg::LATCH_LO], target}; // RL4
					flush_next = 1'b1;                           // RL5
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_reg   <= bid_pkg::RST_ACC;
			latch_reg <= bid_pkg::RST_LATCH;
			pc_reg    <= bid_pkg::RST_PC;
			zero_reg  <= bid_pkg::RST_ZERO;
			skip_reg  <= 1'b0;
			flush_reg <= 1'b0;
			run_reg   <= bid_pkg::RST_RUN;
		end else begin
			acc_reg   <= acc_next;
			latch_reg <= latch_next;
			pc_reg    <= pc_next;
			zero_reg  <= zero_next;
			skip_reg  <= skip_next;
			flush_reg <= flush_next;
			run_reg   <= run_next;
		end
	end

	assign pc         = pc_reg;
	assign instr_nop  = step && !exec;                           // RL2 RL3 RL5
	assign file_addr  = faddr;                                   // RL10
	assign file_we    = exec && file_op && dest;                 // RL8
	assign file_wdata = result;

	//////////////////////////////////////////////////////////////////////////
	// Register read port.
	logic [bid_pkg::DATA_W-1:0]       rdata_reg;
	logic [bid_pkg::DATA_W-1:0]       rdata_next;

	always_comb begin
		rdata_next = '0;
		if (reg_rd) begin
			case (reg_addr)
				bid_pkg::OFS_ACC:    rdata_next = acc_reg;
				bid_pkg::OFS_LATCH:  rdata_next = {1'b0, latch_reg};
				bid_pkg::OFS_STATUS: rdata_next = {5'h00, flush_reg, skip_reg, zero_reg};
				bid_pkg::OFS_PCL:    rdata_next = pc_reg[7:0];
				bid_pkg::OFS_PCH:    rdata_next = {1'b0, pc_reg[bid_pkg::PC_W-1:8]};
				bid_pkg::OFS_CTRL:   rdata_next = {7'h00, run_reg};
				default:             rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_reg <= '0;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	//////////////////////////////////////////////////////////////////////////
	// Checks.
	property p_dsz_value;
		@(posedge clk) disable iff (!rst_n)
		(exec && op == bid_pkg::OP_DSZ && !dest && !(reg_wr && reg_addr == bid_pkg::OFS_ACC))
		|=> acc_reg == 8'($past(file_rdata) - 8'h01);
	endproperty
	a_dsz_value: assert property (p_dsz_value) // RL1
		else $error("decrement result not in accumulator");

	property p_skip_flags;
		@(posedge clk) disable iff (!rst_n)
		(exec && (op == bid_pkg::OP_DSZ || op == bid_pkg::OP_ISZ || op == bid_pkg::OP_BR)
		&& !reg_wr) |=> $stable(zero_reg);
	endproperty
	a_skip_flags: assert property (p_skip_flags) // RL5
		else $error("flag changed by a flag-neutral instruction");

	property p_dsz_skip;
		@(posedge clk) disable iff (!rst_n)
		(exec && op == bid_pkg::OP_DSZ)
		|=> skip_reg == ($past(file_rdata) == 8'h01);
	endproperty
	a_dsz_skip: assert property (p_dsz_skip) // RL2
		else $error("decrement skip decision wrong");

	property p_skip_nop;
		@(posedge clk) disable iff (!rst_n)
		(skip_reg && step) |-> instr_nop && !file_we ##1 !skip_reg;
	endproperty
	a_skip_nop: assert property (p_skip_nop) // RL2
		else $error("skipped instruction was not turned into a no-operation");

	property p_isz_wrap_skip;
		@(posedge clk) disable iff (!rst_n)
		(exec && op == bid_pkg::OP_ISZ && file_rdata == 8'hff)
		|-> result == 8'h00 ##1 skip_reg;
	endproperty
	a_isz_wrap_skip: assert property (p_isz_wrap_skip) // RL3
		else $error("increment-skip did not wrap and skip");

	property p_branch_target;
		@(posedge clk) disable iff (!rst_n)
		(exec && op == bid_pkg::OP_BR)
		|=> pc_reg == {$past(latch_reg[6:3]), $past(instr[10:0])};
	endproperty
	a_branch_target: assert property (p_branch_target) // RL4
		else $error("branch target formed wrongly");

	property p_branch_two_cycles;
		@(posedge clk) disable iff (!rst_n)
		(exec && op == bid_pkg::OP_BR) |=> flush_reg && !skip_reg;
	endproperty
	a_branch_two_cycles: assert property (p_branch_two_cycles) // RL5
		else $error("branch did not arm its second cycle");

	property p_flush_nop;
		@(posedge clk) disable iff (!rst_n)
		(flush_reg && step) |-> instr_nop && !file_we ##1 !flush_reg;
	endproperty
	a_flush_nop: assert property (p_flush_nop) // RL5
		else $error("second branch cycle was not a no-operation");

	property p_ior;
		@(posedge clk) disable iff (!rst_n)
		(exec && op == bid_pkg::OP_IOR)
		|=> acc_reg == ($past(acc_reg) | $past(instr[7:0])) && zero_reg == (acc_reg == 8'h00);
	endproperty
	a_ior: assert property (p_ior) // RL6
		else $error("OR-literal result or zero flag wrong");

	property p_inc_no_skip;
		@(posedge clk) disable iff (!rst_n)
		(exec && op == bid_pkg::OP_INC && !(reg_wr && reg_addr == bid_pkg::OFS_STATUS))
		|=> !skip_reg && zero_reg == ($past(file_rdata) == 8'hff);
	endproperty
	a_inc_no_skip: assert property (p_inc_no_skip) // RL7
		else $error("plain increment skipped or set zero wrongly");

	property p_dest_steer;
		@(posedge clk) disable iff (!rst_n)
		(exec && file_op) |-> file_we == dest && file_wdata == result;
	endproperty
	a_dest_steer: assert property (p_dest_steer) // RL8
		else $error("destination bit did not steer the result");

	property p_acc_kept;
		@(posedge clk) disable iff (!rst_n)
		(exec && file_op && dest && !reg_wr) |=> $stable(acc_reg);
	endproperty
	a_acc_kept: assert property (p_acc_kept) // RL8
		else $error("accumulator written with file destination");

	property p_zero_only_affecting;
		@(posedge clk) disable iff (!rst_n)
		(!reg_wr && !(exec && (op == bid_pkg::OP_INC || op == bid_pkg::OP_IOR)))
		|=> $stable(zero_reg);
	endproperty
	a_zero_only_affecting: assert property (p_zero_only_affecting) // RL9
		else $error("zero flag moved without cause");

	property p_file_addr;
		@(posedge clk) disable iff (!rst_n)
		exec && file_op |-> file_addr == instr[6:0] && file_wdata == 8'(result);
	endproperty
	a_file_addr: assert property (p_file_addr) // RL10
		else $error("file address not taken from the 7-bit field");

endmodule : bid_core
`default_nettype wire

//--- sim/bid_file_model.sv
// Behavioural data file register bank on the far side of the executor.
`timescale 1ns/1ps
`default_nettype none
module bid_file_model (
	// Clock.
	input  wire logic                        clk,
	// File register port.
	input  wire logic [bid_pkg::FADDR_W-1:0] file_addr,
	output logic      [bid_pkg::DATA_W-1:0]  file_rdata,
	input  wire logic                        file_we,
	input  wire logic [bid_pkg::DATA_W-1:0]  file_wdata
);
	logic [bid_pkg::DATA_W-1:0] mem [0:127];
	initial begin
		for (int i = 0; i < 128; i++) begin
			mem[i] = 8'(i) - 8'h40;
		end
	end
	assign file_rdata = mem[file_addr];
	always @(posedge clk) begin
		if (file_we === 1'b1) begin
			mem[file_addr] <= file_wdata;
		end
	end
endmodule : bid_file_model
`default_nettype wire

//--- sim/tb_branch_incdec_or_exec.sv
// Self-checking testbench of the branch and increment/decrement executor.
`timescale 1ns/1ps
`default_nettype none
module tb_branch_incdec_or_exec;
	logic        clk;
	logic        nrst;
	logic        instr_valid;
	logic [13:0] instr;
	logic [14:0] pc;
	logic        instr_nop;
	logic [6:0]  file_addr;
	logic [7:0]  file_rdata;
	logic        file_we;
	logic [7:0]  file_wdata;
	logic [2:0]  reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [7:0]  reg_rdata;
	logic        rd_seen;
	int          mismatches;
	int          n_checks;
	logic [7:0]  rq[$];
	logic        nq[$];
	logic [14:0] wq[$];
	logic [14:0] pq[$];
	logic [7:0]  m_f [0:127];
	logic [7:0]  m_acc;
	logic [6:0]  m_latch;
	logic [14:0] m_pc;
	logic        m_zero;
	logic        m_skip;
	logic        m_flush;
	logic        m_run;
	logic [13:0] mt [6];
	int          k;

	bid_core dut_u (.clk(clk), .nrst(nrst), .instr_valid(instr_valid), .instr(instr),
		.pc(pc), .instr_nop(instr_nop), .file_addr(file_addr), .file_rdata(file_rdata),
		.file_we(file_we), .file_wdata(file_wdata), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	bid_file_model file_u (.clk(clk), .file_addr(file_addr), .file_rdata(file_rdata),
		.file_we(file_we), .file_wdata(file_wdata));

	initial begin
		clk = 1'b0;
		forever begin
			#2.5 clk = ~clk;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : give_verdict

	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
		chk("reg_rdata", 16'(e), 16'(g));
	endtask : chk_rd

	task automatic chk_nop(input logic e, input logic g);
		chk("instr_nop", 16'(e), 16'(g));
	endtask : chk_nop

	task automatic chk_pc(input logic [14:0] e, input logic [14:0] g);
		chk("pc", 16'(e), 16'(g));
	endtask : chk_pc

	task automatic chk_fw(input logic [14:0] e, input logic [14:0] g);
		chk("file write", 16'(e), 16'(g));
	endtask : chk_fw

	task automatic cyc(input logic v, input logic [13:0] ins, input logic rd, input logic wr,
		input logic [2:0] a, input logic [7:0] wd);
		@(posedge clk);
		instr_valid <= v;
		instr <= ins;
		reg_rd <= rd;
		reg_wr <= wr;
		reg_addr <= a;
		reg_wdata <= wd;
	endtask : cyc

	function automatic logic [7:0] rexp(input logic [2:0] a);
		case (a)
			3'h0: return m_acc;
			3'h1: return {1'b0, m_latch};
			3'h2: return {5'h00, m_flush, m_skip, m_zero};
			3'h3: return m_pc[7:0];
			3'h4: return {1'b0, m_pc[14:8]};
			3'h5: return {7'h00, m_run};
			default: return 8'h00;
		endcase
	endfunction : rexp

	task automatic rd(input logic [2:0] a);
		rq.push_back(rexp(a));
		cyc(1'b0, 14'h0000, 1'b1, 1'b0, a, 8'h00);
	endtask : rd

	task automatic rall();
		for (int a = 0; a < 8; a++) begin
			rd(3'(a));
		end
	endtask : rall

	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		if (a == 3'h0) m_acc = d;
		if (a == 3'h1) m_latch = d[6:0];
		if (a == 3'h2) m_zero = d[0];
		if (a == 3'h5) m_run = d[0];
		cyc(1'b0, 14'h0000, 1'b0, 1'b1, a, d);
	endtask : wr

	task automatic exe(input logic [13:0] ins);
		logic [7:0]  f;
		logic [7:0]  r;
		logic [13:0] o;
		f = m_f[ins[6:0]];
		o = ins & bid_pkg::MASK_FILE;
		nq.push_back(m_run && (m_skip || m_flush));
		pq.push_back(m_pc);
		if (m_run !== 1'b1) begin
			r = 8'h00;
		end else if (m_skip || m_flush) begin
			m_skip = 1'b0;
			m_flush = 1'b0;
			m_pc = m_pc + 15'h1;
		end else if ((ins & bid_pkg::MASK_BR) == bid_pkg::MATCH_BR) begin
			m_pc = {m_latch[6:3], ins[10:0]};
			m_flush = 1'b1;
		end else begin
			m_pc = m_pc + 15'h1;
			if (o == bid_pkg::MATCH_IOR) begin
				m_acc = m_acc | ins[7:0];
				m_zero = (m_acc == 8'h00);
			end else if (o == bid_pkg::MATCH_DSZ || o == bid_pkg::MATCH_ISZ ||
				o == bid_pkg::MATCH_INC) begin
				r = (o == bid_pkg::MATCH_DSZ) ? f - 8'h01 : f + 8'h01;
				if (o == bid_pkg::MATCH_INC) m_zero = (r == 8'h00);
				else m_skip = (r == 8'h00);
				if (ins[7]) begin
					m_f[ins[6:0]] = r;
					wq.push_back({ins[6:0], r});
				end else begin
					m_acc = r;
				end
			end
		end
		cyc(1'b1, ins, 1'b0, 1'b0, 3'h0, 8'h00);
	endtask : exe
	////////////////////////////////////////////////////////////////////////////////
	always @(posedge clk) rd_seen <= reg_rd;
	always @(negedge clk) begin
		if (rd_seen === 1'b1) begin
			if (rq.size() == 0) chk("reg_rdata unexpected", 16'h0, 16'h1);
			else chk_rd(rq.pop_front(), reg_rdata);
		end
		if (instr_valid === 1'b1) begin
			if (nq.size() == 0) chk("instr_nop unexpected", 16'h0, 16'h1);
			else chk_nop(nq.pop_front(), instr_nop);
			if (pq.size() == 0) chk("pc unexpected", 16'h0, 16'h1);
			else chk_pc(pq.pop_front(), pc);
		end
		if (file_we === 1'b1) begin
			if (wq.size() == 0) chk("file write unexpected", 16'h0, 16'h1);
			else chk_fw(wq.pop_front(), {file_addr, file_wdata});
		end
	end

	initial begin
		#50000;
		mismatches++;
		give_verdict();
	end

	initial begin
		nrst = 1'b0;
		{instr_valid, instr, reg_rd, reg_wr, reg_addr, reg_wdata, rd_seen} = '0;
		mismatches = 0;
		n_checks = 0;
		m_acc = bid_pkg::RST_ACC;
		m_latch = bid_pkg::RST_LATCH;
		m_pc = bid_pkg::RST_PC;
		m_zero = bid_pkg::RST_ZERO;
		m_run = bid_pkg::RST_RUN;
		{m_skip, m_flush} = 2'b00;
		mt = '{bid_pkg::MATCH_DSZ, bid_pkg::MATCH_ISZ, bid_pkg::MATCH_INC, bid_pkg::MATCH_BR,
			bid_pkg::MATCH_IOR, 14'h0000};
		for (int i = 0; i < 128; i++) m_f[i] = 8'(i) - 8'h40;
		void'($urandom(32'h2b584610));
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		rall();
		wr(3'h0, 8'ha5);
		wr(3'h1, 8'hff);
		wr(3'h2, 8'hff);
		wr(3'h3, 8'h12);
		wr(3'h6, 8'h34);
		rall();
		exe(14'h0bc1);
		rd(3'h2);
		exe(14'h38ff);
		exe(14'h0b41);
		exe(14'h38ff);
		exe(14'h0f3f);
		exe(14'h0aff);
		exe(14'h0abf);
		rall();
		wr(3'h0, 8'h00);
		exe(14'h3800);
		rd(3'h2);
		exe(14'h385a);
		exe(14'h2fff);
		exe(14'h0abf);
		rall();
		wr(3'h1, 8'h2a);
		exe(14'h2801);
		rall();
		wr(3'h5, 8'h00);
		exe(14'h0abf);
		rall();
		wr(3'h5, 8'h01);
		for (int n = 0; n < 300; n++) begin
			k = $urandom_range(5);
			exe(mt[k] | (14'($urandom) & ~((k == 3) ? bid_pkg::MASK_BR : bid_pkg::MASK_FILE)));
			if ($urandom_range(1) == 1) rd(3'($urandom_range(7)));
		end
		rall();
		cyc(1'b0, 14'h0000, 1'b0, 1'b0, 3'h0, 8'h00);
		repeat (3) @(posedge clk);
		chk("pending results", 16'h0, 16'(rq.size() + nq.size() + wq.size() + pq.size()));
		give_verdict();
	end
endmodule : tb_branch_incdec_or_exec
`default_nettype wire
